// [hdl/loader_pkg.sv]
package loader_pkg;

  // Reference geometry: a 4 x 4 RAM and four blocks on the ring
  localparam int DATA_W_DEF = 4;
  localparam int ADDR_W_DEF = 2;
  localparam int NBLK_DEF   = 4;

  // Largest block that one load session is sized to fill
  localparam int BLOCK_BITS_MAX = 4608;

  // User instruction codes seen on the access macro command port
  localparam int             CMD_W         = 8;
  localparam logic [7:0]     CMD_LOAD_DATA = 8'h10;
  localparam logic [7:0]     CMD_LOAD_ADDR = 8'h11;
  localparam logic [7:0]     CMD_READBACK  = 8'h12;

  // Readback capture wait after the read clock edge, in clk cycles
  localparam logic [1:0]     RB_WAIT       = 2'h3;
  localparam logic [1:0]     RB_TAKE       = 2'h1;

  // Reset values
  localparam logic           RAM_CLK_RST   = 1'b1;

  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_DATA,
    MODE_ADDR,
    MODE_READ
  } mode_e;

endpackage

// [hdl/jtag_sync_if.sv]
`timescale 1ns/1ps
interface jtag_sync_if #(
  parameter int DATA_W = 4
);
  import loader_pkg::*;
  logic              sclk;
  logic              sdin;
  logic              upd;
  logic [CMD_W-1:0]  cmd;
  logic [DATA_W-1:0] rdata;

  modport src (output sclk, output sdin, output upd, output cmd, output rdata);
  modport dst (input  sclk, input  sdin, input  upd, input  cmd, input  rdata);
endinterface

// [hdl/jtag_in_sync.sv]
`timescale 1ns/1ps
module jtag_in_sync
  import loader_pkg::*;
#(
  parameter int DATA_W = 4
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Raw inputs from the access macro and the RAM
  input  wire logic              sclk_raw,
  input  wire logic              sdin_raw,
  input  wire logic              upd_raw,
  input  wire logic [CMD_W-1:0]  cmd_raw,
  input  wire logic [DATA_W-1:0] rdata_raw,
  // Synchronised copies
  jtag_sync_if.src               so
);
  localparam int N = 3 + CMD_W + DATA_W;

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
  } sync_s;

  sync_s q;
  sync_s d;

  // Stage one is read by stage two only
  always_comb begin
    d    = q;
    d.s1 = {sclk_raw, sdin_raw, upd_raw, cmd_raw, rdata_raw};
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign so.sclk  = q.s2[N-1];
  assign so.sdin  = q.s2[N-2];
  assign so.upd   = q.s2[N-3];
  assign so.cmd   = q.s2[DATA_W +: CMD_W];
  assign so.rdata = q.s2[DATA_W-1:0];
endmodule

// [hdl/jtag_ram_init_loader.sv]
// Summary of operation
// - Each block loads on its own, and one session can fill a whole block of 4,608 bits.
// - Command, data and clock from the user JTAG access macro drive the RAM ports in step.
// - One chip select per block picks the block being loaded, stepped by a ring counter.
// - The serial-in parallel-out register is as wide as the RAM data word.
// - Serial data bits are shifted in on the user data-register shift clock.
// - A word goes to the write data port only after the shift register holds all its bits.
// - The shift register output is registered so data lines up with address and write clock.
// - The write address comes from a TAP-loaded address shift register or an internal counter.
// - The write clock drives the RAM clock and data, address and selects are synced to it.
// - RAM clock is the inverted update strobe, so address and data settle in Update-DR.
// - One clock output is the write clock while loading and the read clock in readback.
// - A readback mode reads the RAM contents back out for checking.
// - Default sizes fit the reference 4 x 4 RAM.
`timescale 1ns/1ps
module jtag_ram_init_loader
  import loader_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int NBLK   = NBLK_DEF
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // User JTAG access macro
  input  wire logic [CMD_W-1:0]  user_command,
  input  wire logic              user_serial_data_in,
  input  wire logic              user_dr_shift_clock,
  input  wire logic              register_update_strobe,
  output logic                   user_serial_data_out,
  // RAM ports
  output logic [NBLK-1:0]        ram_cs,
  output logic [ADDR_W-1:0]      ram_addr,
  output logic [DATA_W-1:0]      ram_wdata,
  output logic                   ram_wen,
  output logic                   ram_clk,
  input  wire logic [DATA_W-1:0] ram_rdata,
  // Status
  output logic                   readback_active
);
  localparam int CNT_W = $clog2(DATA_W + ADDR_W) + 1;
  localparam logic [ADDR_W-1:0] ADDR_LAST = '1;
  localparam logic [CNT_W-1:0]  WORD_BITS = CNT_W'(DATA_W);
  localparam logic [CNT_W-1:0]  ADDR_BITS = CNT_W'(ADDR_W);
  localparam logic [NBLK-1:0]   RING_RST  = NBLK'(1);

  typedef struct packed {
    logic              sclk_prev;
    logic              upd_prev;
    mode_e             mode;
    logic [DATA_W-1:0] sr;
    logic [ADDR_W-1:0] ash;
    logic [CNT_W-1:0]  nbits;
    logic [ADDR_W-1:0] addr;
    logic [NBLK-1:0]   ring;
    logic [NBLK-1:0]   cs;
    logic [DATA_W-1:0] wdata;
    logic              wen;
    logic              clk_out;
    logic              adv;
    logic [1:0]        pend;
    logic [DATA_W-1:0] rb;
  } st_s;

  jtag_sync_if #(.DATA_W(DATA_W)) sy ();

  jtag_in_sync #(.DATA_W(DATA_W)) u_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .sclk_raw  (user_dr_shift_clock),
    .sdin_raw  (user_serial_data_in),
    .upd_raw   (register_update_strobe),
    .cmd_raw   (user_command),
    .rdata_raw (ram_rdata),
    .so        (sy.src)
  );

  st_s q;
  st_s d;

  logic  sclk_rise;
  logic  upd_rise;
  logic  upd_fall;
  mode_e mode_now;

  assign sclk_rise = sy.sclk && !q.sclk_prev;
  assign upd_rise  = sy.upd && !q.upd_prev;
  assign upd_fall  = !sy.upd && q.upd_prev;

  // The host picks the mode by loading a user instruction
  always_comb begin
    if (sy.cmd == CMD_LOAD_DATA) begin
      mode_now = MODE_DATA;
    end else if (sy.cmd == CMD_LOAD_ADDR) begin
      mode_now = MODE_ADDR;
    end else if (sy.cmd == CMD_READBACK) begin
      mode_now = MODE_READ;
    end else begin
      mode_now = MODE_IDLE;
    end
  end

  always_comb begin
    d           = q;
    d.sclk_prev = sy.sclk;
    d.upd_prev  = sy.upd;
    d.mode      = mode_now;
    d.adv       = 1'b0;
    // Inverted strobe: falls as Update-DR starts, rises as it ends
    d.clk_out   = !sy.upd;
    if (sclk_rise) begin
      case (q.mode)
        MODE_DATA: begin
          d.sr = {sy.sdin, q.sr[DATA_W-1:1]};
        end
        MODE_ADDR: begin
          d.ash = {sy.sdin, q.ash[ADDR_W-1:1]};
        end
        MODE_READ: begin
          d.rb = {1'b0, q.rb[DATA_W-1:1]};
        end
        default: begin
          d.sr = q.sr;
        end
      endcase
      if (q.nbits != '1) begin
        d.nbits = q.nbits + 1'b1;
      end
    end
    if (upd_rise) begin
      d.nbits = '0;
      case (q.mode)
        MODE_DATA: begin
          // A short scan leaves the RAM untouched
          if (q.nbits >= WORD_BITS) begin
            d.wdata = q.sr;
            d.wen   = 1'b1;
          end
        end
        MODE_ADDR: begin
          if (q.nbits >= ADDR_BITS) begin
            d.addr = q.ash;
          end
        end
        default: begin
          d.wen = 1'b0;
        end
      endcase
    end
    // Step only after the RAM clock has risen, so the edge sees a stable address
    if (upd_fall && (q.wen || q.mode == MODE_READ)) begin
      d.adv = 1'b1;
      if (q.mode == MODE_READ) begin
        d.pend = RB_WAIT;
      end
    end
    if (q.adv) begin
      d.wen  = 1'b0;
      d.addr = q.addr + 1'b1;
      if (q.addr == ADDR_LAST) begin
        d.ring = {q.ring[NBLK-2:0], q.ring[NBLK-1]};
      end
    end
    // Read data lands after the read edge and is then resynchronised
    if (q.pend != '0) begin
      d.pend = q.pend - 1'b1;
      if (q.pend == RB_TAKE) begin
        d.rb = sy.rdata;
      end
    end
    d.cs = (d.mode == MODE_IDLE) ? '0 : d.ring;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q         <= '0;
      q.mode    <= MODE_IDLE;
      q.ring    <= RING_RST;
      q.clk_out <= RAM_CLK_RST;
    end else begin
      q <= d;
    end
  end

  assign ram_cs               = q.cs;
  assign ram_addr             = q.addr;
  assign ram_wdata            = q.wdata;
  assign ram_wen              = q.wen;
  assign ram_clk              = q.clk_out;
  assign user_serial_data_out = q.rb[0];
  assign readback_active      = (q.mode == MODE_READ);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // An address load is the one update that may move the address
  clk_inverse_a: assert property (upd_rise |=> !ram_clk ##0
                                  ($past(q.mode) == MODE_ADDR || $stable(ram_addr)))
    else $error("ram clock did not fall on update strobe");

  clk_release_a: assert property (upd_fall |=> ram_clk)
    else $error("ram clock did not rise at end of update");

  shift_in_a: assert property (sclk_rise && q.mode == MODE_DATA
                               |=> q.sr[DATA_W-1] == $past(sy.sdin))
    else $error("serial bit not shifted into word register");

  word_full_a: assert property ($rose(ram_wen) |-> $past(q.nbits) >= WORD_BITS)
    else $error("write raised before a whole word was shifted");

  data_pipe_a: assert property ($rose(ram_wen) |-> ram_wdata == $past(q.sr))
    else $error("write data differs from shifted word");

  addr_hold_a: assert property ($rose(ram_clk) |-> ram_addr == $past(ram_addr, 2))
    else $error("address moved around the ram clock edge");

  addr_step_a: assert property ($rose(ram_clk) && ram_wen
                                |=> ram_addr == ADDR_W'($past(ram_addr) + 1'b1))
    else $error("address counter did not step after write");

  ring_wrap_a: assert property ($rose(ram_clk) && ram_wen && ram_addr == ADDR_LAST
                                |=> q.ring == {$past(q.ring[NBLK-2:0]), $past(q.ring[NBLK-1])})
    else $error("block select did not move on address wrap");

  one_select_a: assert property ($onehot0(ram_cs) && $onehot(q.ring))
    else $error("more than one block selected");

  addr_load_a: assert property (upd_rise && q.mode == MODE_ADDR && q.nbits >= ADDR_BITS
                                |=> ram_addr == $past(q.ash))
    else $error("loaded address not applied");

  read_nowrite_a: assert property (readback_active |-> !ram_wen)
    else $error("write enable high during readback");

  wen_drop_a: assert property ($rose(ram_clk) && ram_wen |=> !ram_wen)
    else $error("write enable stayed high after the write edge");

  wen_hold_a: assert property (ram_wen && !q.adv && !upd_rise |=> ram_wen)
    else $error("write enable dropped before the write edge");

  adv_cause_a: assert property (q.adv |-> $past(upd_fall))
    else $error("address step without an update end");

  clk_follow_a: assert property (ram_clk != $past(sy.upd))
    else $error("ram clock is not the inverted update strobe");

  cs_idle_a: assert property (q.mode == MODE_IDLE |-> ram_cs == '0)
    else $error("block selected with no user command");

  cs_ring_a: assert property (q.mode != MODE_IDLE |-> ram_cs == q.ring)
    else $error("block select differs from ring counter");

  ring_quiet_a: assert property (!(q.adv && q.addr == ADDR_LAST) |=> $stable(q.ring))
    else $error("ring counter moved without an address wrap");

  addr_quiet_a: assert property (!upd_rise && !q.adv |=> $stable(ram_addr))
    else $error("address moved without a load or a step");

  wdata_hold_a: assert property (!upd_rise |=> $stable(ram_wdata))
    else $error("write data moved outside an update");

  short_scan_a: assert property (upd_rise && q.mode == MODE_DATA && q.nbits < WORD_BITS
                                 |=> $stable(ram_wdata) && !$rose(ram_wen))
    else $error("short scan reached the ram");

  nbits_clear_a: assert property (upd_rise |=> q.nbits == '0)
    else $error("bit count not cleared by update");

  // Internal shift state; the port checks above cover the RAM side
  nbits_count_a: assert property (sclk_rise && !upd_rise && q.nbits != '1
                                  |=> q.nbits == CNT_W'($past(q.nbits) + 1'b1))
    else $error("bit count did not follow the shift clock");

  shift_mid_a: assert property (sclk_rise && q.mode == MODE_DATA
                                |=> q.sr[DATA_W-2:0] == $past(q.sr[DATA_W-1:1]))
    else $error("word register did not shift right");

  sr_hold_a: assert property (!(sclk_rise && q.mode == MODE_DATA) |=> $stable(q.sr))
    else $error("word register moved without a data shift");

  addr_shift_a: assert property (sclk_rise && q.mode == MODE_ADDR
                                 |=> q.ash[ADDR_W-1] == $past(sy.sdin))
    else $error("serial bit not shifted into address register");

  ash_mid_a: assert property (sclk_rise && q.mode == MODE_ADDR
                              |=> q.ash[ADDR_W-2:0] == $past(q.ash[ADDR_W-1:1]))
    else $error("address register did not shift right");

  ash_hold_a: assert property (!(sclk_rise && q.mode == MODE_ADDR) |=> $stable(q.ash))
    else $error("address register moved without an address shift");

  mode_decode_a: assert property (q.mode == MODE_READ |-> $past(sy.cmd) == CMD_READBACK)
    else $error("readback mode without the readback command");

  pend_set_a: assert property (upd_fall && q.mode == MODE_READ |=> q.pend == RB_WAIT)
    else $error("read capture wait not started at read edge");

  rb_load_a: assert property (q.pend == RB_TAKE |=> q.rb == $past(sy.rdata))
    else $error("read word not captured");

  rb_shift_a: assert property (sclk_rise && q.mode == MODE_READ && q.pend != RB_TAKE
                               |=> q.rb == {1'b0, $past(q.rb[DATA_W-1:1])})
    else $error("read word did not shift out");

  rb_hold_a: assert property (q.pend != RB_TAKE && !(sclk_rise && q.mode == MODE_READ)
                              |=> $stable(q.rb))
    else $error("read word moved without a load or a shift");

endmodule

// [dv/ram_model.sv]
`timescale 1ns/1ps
module ram_model (
  // RAM ports seen from the memory
  input  wire logic       ram_clk,
  input  wire logic [3:0] ram_cs,
  input  wire logic [1:0] ram_addr,
  input  wire logic [3:0] ram_wdata,
  input  wire logic       ram_wen,
  output logic [3:0]      ram_rdata
);
  logic [3:0] mem [4][4];

  initial ram_rdata = 4'h0;

  always @(posedge ram_clk) begin
    // Shared bus floats unless a selected block is read, so show a changing pattern
    ram_rdata <= ~ram_rdata;
    for (int b = 0; b < 4; b++) begin
      if (ram_cs[b] && ram_wen) begin
        mem[b][ram_addr] <= ram_wdata;
      end
      if (ram_cs[b] && !ram_wen) begin
        ram_rdata <= mem[b][ram_addr];
      end
    end
  end
endmodule

// [dv/jtag_ram_init_loader_test.sv]
`timescale 1ns/1ps
module jtag_ram_init_loader_test;
  import loader_pkg::*;
  // Clock cycles in one half of the 160 ns link clock
  localparam int HALF = 16;
  logic       clk, rst_n, sclk, sdin, upd, sout, wen, rclk, rb_act;
  logic [7:0] cmd;
  logic [3:0] cs, wdata, rdata, w, got;
  logic [1:0] addr;
  logic [3:0] exp_mem [4][4];
  int         fail_count, samples_checked, cyc, blk, a;

  jtag_ram_init_loader i_dut (.clk(clk), .rst_n(rst_n), .user_command(cmd),
    .user_serial_data_in(sdin), .user_dr_shift_clock(sclk),
    .register_update_strobe(upd), .user_serial_data_out(sout), .ram_cs(cs),
    .ram_addr(addr), .ram_wdata(wdata), .ram_wen(wen), .ram_clk(rclk),
    .ram_rdata(rdata), .readback_active(rb_act));

  ram_model i_ram (.ram_clk(rclk), .ram_cs(cs), .ram_addr(addr), .ram_wdata(wdata),
    .ram_wen(wen), .ram_rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      complete_run();
    end
  end

  function automatic logic [3:0] onehot(input int b);
    return 4'h1 << b;
  endfunction

  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic waitn(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic shift(input logic b);
    sdin = b;
    waitn(HALF);
    sclk = 1'b1;
    waitn(1);
    // Line released just after the rise: show the inverse of the last value
    sdin = ~b;
    waitn(HALF - 1);
    sclk = 1'b0;
  endtask

  // Bits go out LSB first; the link clock stands low outside frames
  task automatic scan(input logic [3:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      shift(v[i]);
    end
  endtask

  task automatic update();
    upd = 1'b1;
    waitn(HALF);
    upd = 1'b0;
    waitn(HALF);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    sclk = 1'b0;
    sdin = 1'b0;
    upd = 1'b0;
    cmd = 8'h00;
    fail_count = 0;
    samples_checked = 0;
    cyc = 0;
    w = 4'($urandom(67934));
    waitn(2);
    rst_n = 1'b1;
    waitn(3);
    chk("cs", 4'h0, cs);
    chk("ram_clk", 4'h1, {3'h0, rclk});
    chk("wen", 4'h0, {3'h0, wen});
    chk("readback", 4'h0, {3'h0, rb_act});
    upd = 1'b1;
    waitn(HALF);
    chk("idle ram_clk", 4'h0, {3'h0, rclk});
    chk("idle cs", 4'h0, cs);
    upd = 1'b0;
    waitn(HALF);
    $display("test idle done");

    cmd = CMD_LOAD_ADDR;
    scan(4'h2, 2);
    update();
    chk("addr load", 4'h2, {2'h0, addr});
    $display("test address load done");

    cmd = CMD_LOAD_DATA;
    blk = 0;
    a = 2;
    for (int i = 0; i < 16; i++) begin
      w = 4'($urandom());
      exp_mem[blk][a] = w;
      scan(w, 4);
      upd = 1'b1;
      waitn(HALF);
      chk("wdata", w, wdata);
      chk("cs", onehot(blk), cs);
      chk("addr", 4'(a), {2'h0, addr});
      chk("ram_clk", 4'h0, {3'h0, rclk});
      chk("wen", 4'h1, {3'h0, wen});
      upd = 1'b0;
      waitn(HALF);
      a = (a + 1) % 4;
      blk = (a == 0) ? (blk + 1) % 4 : blk;
      chk("addr step", 4'(a), {2'h0, addr});
      if (i == 5) begin
        scan(w, 3);
        upd = 1'b1;
        waitn(HALF);
        chk("short wen", 4'h0, {3'h0, wen});
        upd = 1'b0;
        waitn(HALF);
        chk("short addr", 4'(a), {2'h0, addr});
      end
    end
    chk("ring wrap", onehot(0), cs);
    $display("test data load done");

    cmd = CMD_LOAD_ADDR;
    scan(4'h0, 2);
    update();
    cmd = CMD_READBACK;
    for (int k = 0; k < 4; k++) begin
      update();
      chk("rb active", 4'h1, {3'h0, rb_act});
      // Reading the last address wraps the counter and moves the ring on
      chk("rb cs", onehot((k + 1) / 4), cs);
      for (int i = 0; i < 4; i++) begin
        got[i] = sout;
        shift(1'($urandom()));
      end
      chk("rb word", exp_mem[0][k], got);
    end
    $display("test readback done");
    complete_run();
  end
endmodule
